/* File: core/mip_regs.vh */
// Address map, field positions, reset values and timing counts for the I/O port block.
`ifndef MIP_REGS_VH
`define MIP_REGS_VH
// ----------------------------------------------------------------------------
// Data-memory locations of the port block
// ----------------------------------------------------------------------------
`define MIP_ADDR_WIDE_DATA   8'h_00D0
`define MIP_ADDR_WIDE_CFG    8'h_00D1
`define MIP_ADDR_WIDE_PINS   8'h_00D2
`define MIP_ADDR_MIX_DATA    8'h_00D4
`define MIP_ADDR_MIX_CFG     8'h_00D5
`define MIP_ADDR_MIX_PINS    8'h_00D6
`define MIP_ADDR_IN_PINS     8'h_00D7
`define MIP_ADDR_OUT_DATA    8'h_00DC
`define MIP_ADDR_CTRL        8'h_00EE
`define MIP_ADDR_STATUS      8'h_00EF
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define MIP_MIX_HALT_BIT     7
`define MIP_MIX_IN_ONLY_MASK 8'h_00C0
`define MIP_RST_PORT         8'h_0000
`define MIP_RST_OUT_PORT     4'h_F
`define MIP_RST_CTRL         8'h_0000
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MIP_OSC_DIVIDE       10
`endif

/* File: core/mip_clkdiv.v */
// Divider making the instruction-cycle enable pulse from the oscillator clock.
`timescale 1ns/10ps
module mip_clkdiv #(
  parameter DIVIDE = 10
) (
  // Clock and reset
  input  wire clk,
  input  wire resetn,
  // Control
  input  wire run,
  // Enable out
  output wire cycle_en
);
  reg [7:0] count_reg;

  // Counts oscillator edges; frozen while halted so state holds statically.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= 8'h_0000;
    end else if (run) begin
      if (count_reg == DIVIDE[7:0] - 8'h_0001) begin
        count_reg <= 8'h_0000;
      end else begin
        count_reg <= count_reg + 8'h_0001;
      end
    end
  end

  assign cycle_en = run && (count_reg == DIVIDE[7:0] - 8'h_0001);
endmodule

/* File: core/mip_io_ports.v */
// General-purpose I/O ports with halt control and reset initialisation.
`timescale 1ns/10ps
`include "mip_regs.vh"
// Functional notes
// - Wide port: eight pins, each with its own data and configuration bit.
// - Cfg0/data0 Hi-Z, cfg0/data1 pull-up, cfg1/data0 drive low, cfg1/data1 high.
// - Each bidirectional port has data, configuration and pin-input locations.
// - Four-bit input-only port, never driven, no configuration register.
// - Mixed port: bits 0-5 configurable, bits 6 and 7 input only.
// - Config bits 6 and 7 of mixed port ignore writes and read zero.
// - Setting mixed-port data bit 7 halts all processor activity.
// - Mixed pins carry interrupt, timer, serial out, clock, serial in functions.
// - Crystal option: bit 7 is oscillator output; else continue input.
// - Four-bit output port forced high while reset input is low.
// - Reset clears counter, status, control and both port register sets.
// - Device stays in reset for as long as reset is held low.
// - Every port and register bit can be set, cleared or tested singly.
// - Instruction cycle clock is the oscillator input divided by ten.
// - Static operation; a stopped clock freezes all state.
// - Rising continue edge resumes without reinitialisation and clears halt bit.
module mip_io_ports #(
  parameter DIVIDE = `MIP_OSC_DIVIDE
) (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Clock option strap: high selects crystal
  input  wire       crystal_option,
  // Processor data-memory access
  input  wire [7:0] mem_addr,
  input  wire       mem_wr,
  input  wire [7:0] mem_wdata,
  input  wire       mem_bit_op,
  input  wire [2:0] mem_bit_sel,
  input  wire       mem_bit_val,
  output reg  [7:0] mem_rdata,
  output wire       mem_hit,
  // Wide bidirectional port
  input  wire [7:0] wide_in,
  output wire [7:0] wide_out,
  output wire [7:0] wide_oe,
  output wire [7:0] wide_pullup,
  // Mixed port
  input  wire [7:0] mix_in,
  output wire [5:0] mix_out,
  output wire [5:0] mix_oe,
  output wire [5:0] mix_pullup,
  // Oscillator output / continue pin
  input  wire       osc_clock_out_or_continue_in,
  output wire       osc_clock_out_or_continue_out,
  output wire       osc_clock_out_or_continue_oe,
  // Input-only and output-only ports
  input  wire [3:0] in_port,
  output wire [3:0] out_port,
  // Alternate functions
  output wire       external_irq_input,
  output wire       timer_io_in,
  input  wire       timer_io_out,
  input  wire       timer_io_drive,
  input  wire       serial_data_out,
  input  wire       serial_enable,
  output wire       serial_shift_clock_in,
  input  wire       serial_shift_clock_out,
  output wire       serial_data_in,
  // Core state
  output wire       halted,
  output wire       cycle_en,
  output wire [7:0] processor_status_reg,
  output wire [7:0] control_reg
);
  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg  [7:0] wide_data_reg;
  reg  [7:0] wide_cfg_reg;
  reg  [7:0] mix_data_reg;
  reg  [5:0] mix_cfg_reg;
  reg  [3:0] out_data_reg;
  reg  [7:0] ctrl_reg;
  reg  [7:0] status_reg;
  reg  [7:0] wide_s1_reg;
  reg  [7:0] wide_s2_reg;
  reg  [7:0] mix_s1_reg;
  reg  [7:0] mix_s2_reg;
  reg  [3:0] in_s1_reg;
  reg  [3:0] in_s2_reg;
  reg        cont_s1_reg;
  reg        cont_s2_reg;
  reg        cont_prev_reg;
  reg        crystal_reg;
  reg  [7:0] wr_value;
  wire       halt_bit;
  wire       cont_rise;
  wire       run;

  // Read-modify-write merge so a single bit can be set or cleared.
  function [7:0] mip_merge;
    input [7:0] old_val;
    input       bit_op;
    input [2:0] bit_sel;
    input       bit_val;
    input [7:0] whole;
    begin
      mip_merge = whole;
      if (bit_op) begin
        mip_merge = old_val;
        mip_merge[bit_sel] = bit_val;
      end
    end
  endfunction

  // Pin-driver encoding shared by both bidirectional ports.
  function [1:0] mip_pad;
    input cfg;
    input data;
    begin
      mip_pad = {cfg, ~cfg & data};
    end
  endfunction

  // --------------------------------------------------------------------------
  // Halt control and cycle divider
  // --------------------------------------------------------------------------
  assign halt_bit  = mix_data_reg[`MIP_MIX_HALT_BIT];
  assign cont_rise = cont_s2_reg & ~cont_prev_reg & ~crystal_reg;
  assign run       = ~halt_bit;
  assign halted    = halt_bit;

  mip_clkdiv #(
    .DIVIDE (DIVIDE)
  ) u_div (
    .clk      (clk),
    .resetn   (resetn),
    .run      (run),
    .cycle_en (cycle_en)
  );

  // Clock option is caught after reset release; a strap is not a reset value.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crystal_reg <= 1'b0;
    end else begin
      crystal_reg <= crystal_option;
    end
  end

  // Continue pin sampled every clock, since the cycle enable stops in halt.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cont_s1_reg   <= 1'b0;
      cont_s2_reg   <= 1'b0;
      cont_prev_reg <= 1'b0;
    end else begin
      cont_s1_reg   <= osc_clock_out_or_continue_in;
      cont_s2_reg   <= cont_s1_reg;
      cont_prev_reg <= cont_s2_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Input synchronisers at instruction-cycle rate
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wide_s1_reg <= 8'h_0000;
      wide_s2_reg <= 8'h_0000;
      mix_s1_reg  <= 8'h_0000;
      mix_s2_reg  <= 8'h_0000;
      in_s1_reg   <= 4'h_0;
      in_s2_reg   <= 4'h_0;
    end else if (cycle_en) begin
      wide_s1_reg <= wide_in;
      wide_s2_reg <= wide_s1_reg;
      mix_s1_reg  <= {cont_s2_reg, mix_in[6:0]};
      mix_s2_reg  <= mix_s1_reg;
      in_s1_reg   <= in_port;
      in_s2_reg   <= in_s1_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // Writes count only on a cycle enable; halt stops them with the divider.
  always @* begin
    wr_value = 8'h_0000;
    if (mem_addr == `MIP_ADDR_WIDE_DATA) begin
      wr_value = mip_merge(wide_data_reg, mem_bit_op, mem_bit_sel, mem_bit_val, mem_wdata);
    end else if (mem_addr == `MIP_ADDR_WIDE_CFG) begin
      wr_value = mip_merge(wide_cfg_reg, mem_bit_op, mem_bit_sel, mem_bit_val, mem_wdata);
    end else if (mem_addr == `MIP_ADDR_MIX_DATA) begin
      wr_value = mip_merge(mix_data_reg, mem_bit_op, mem_bit_sel, mem_bit_val, mem_wdata);
    end else if (mem_addr == `MIP_ADDR_MIX_CFG) begin
      wr_value = mip_merge({2'b00, mix_cfg_reg}, mem_bit_op, mem_bit_sel, mem_bit_val,
                           mem_wdata);
    end else if (mem_addr == `MIP_ADDR_OUT_DATA) begin
      wr_value = mip_merge({4'h_0, out_data_reg}, mem_bit_op, mem_bit_sel, mem_bit_val,
                           mem_wdata);
    end else if (mem_addr == `MIP_ADDR_CTRL) begin
      wr_value = mip_merge(ctrl_reg, mem_bit_op, mem_bit_sel, mem_bit_val, mem_wdata);
    end else if (mem_addr == `MIP_ADDR_STATUS) begin
      wr_value = mip_merge(status_reg, mem_bit_op, mem_bit_sel, mem_bit_val, mem_wdata);
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wide_data_reg <= `MIP_RST_PORT;
      wide_cfg_reg  <= `MIP_RST_PORT;
      mix_data_reg  <= `MIP_RST_PORT;
      mix_cfg_reg   <= 6'h_00;
      out_data_reg  <= `MIP_RST_OUT_PORT;
      ctrl_reg      <= `MIP_RST_CTRL;
      status_reg    <= `MIP_RST_CTRL;
    end else begin
      if (cycle_en && mem_wr) begin
        if (mem_addr == `MIP_ADDR_WIDE_DATA) begin
          wide_data_reg <= wr_value;
        end else if (mem_addr == `MIP_ADDR_WIDE_CFG) begin
          wide_cfg_reg <= wr_value;
        end else if (mem_addr == `MIP_ADDR_MIX_DATA) begin
          mix_data_reg <= wr_value;
        end else if (mem_addr == `MIP_ADDR_MIX_CFG) begin
          mix_cfg_reg <= wr_value[5:0];
        end else if (mem_addr == `MIP_ADDR_OUT_DATA) begin
          out_data_reg <= wr_value[3:0];
        end else if (mem_addr == `MIP_ADDR_CTRL) begin
          ctrl_reg <= wr_value;
        end else if (mem_addr == `MIP_ADDR_STATUS) begin
          status_reg <= wr_value;
        end
      end
      // Continue edge resumes where halt left off and drops the halt bit.
      if (halt_bit && cont_rise) begin
        mix_data_reg[7] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  assign mem_hit = (mem_addr == `MIP_ADDR_WIDE_DATA) || (mem_addr == `MIP_ADDR_WIDE_CFG) ||
                   (mem_addr == `MIP_ADDR_WIDE_PINS) || (mem_addr == `MIP_ADDR_MIX_DATA) ||
                   (mem_addr == `MIP_ADDR_MIX_CFG) || (mem_addr == `MIP_ADDR_MIX_PINS) ||
                   (mem_addr == `MIP_ADDR_IN_PINS) || (mem_addr == `MIP_ADDR_OUT_DATA) ||
                   (mem_addr == `MIP_ADDR_CTRL) || (mem_addr == `MIP_ADDR_STATUS);

  // Unmapped locations read zero; read data is registered.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_rdata <= 8'h_0000;
    end else if (mem_addr == `MIP_ADDR_WIDE_DATA) begin
      mem_rdata <= wide_data_reg;
    end else if (mem_addr == `MIP_ADDR_WIDE_CFG) begin
      mem_rdata <= wide_cfg_reg;
    end else if (mem_addr == `MIP_ADDR_WIDE_PINS) begin
      mem_rdata <= wide_s2_reg;
    end else if (mem_addr == `MIP_ADDR_MIX_DATA) begin
      mem_rdata <= mix_data_reg;
    end else if (mem_addr == `MIP_ADDR_MIX_CFG) begin
      mem_rdata <= {2'b00, mix_cfg_reg};
    end else if (mem_addr == `MIP_ADDR_MIX_PINS) begin
      mem_rdata <= mix_s2_reg;
    end else if (mem_addr == `MIP_ADDR_IN_PINS) begin
      mem_rdata <= {4'h_0, in_s2_reg};
    end else if (mem_addr == `MIP_ADDR_OUT_DATA) begin
      mem_rdata <= {4'h_0, out_data_reg};
    end else if (mem_addr == `MIP_ADDR_CTRL) begin
      mem_rdata <= ctrl_reg;
    end else if (mem_addr == `MIP_ADDR_STATUS) begin
      mem_rdata <= status_reg;
    end else begin
      mem_rdata <= 8'h_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_wide
      wire [1:0] pad = mip_pad(wide_cfg_reg[gi], wide_data_reg[gi]);
      assign wide_oe[gi]     = pad[1];
      assign wide_pullup[gi] = pad[0];
      assign wide_out[gi]    = wide_data_reg[gi];
    end
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_mix
      wire [1:0] pad = mip_pad(mix_cfg_reg[gi], mix_data_reg[gi]);
      wire       alt_drive;
      wire       alt_value;
      // Serial and timer functions take the pin only when their unit claims it.
      if (gi == 3) begin : g_tmr
        assign alt_drive = timer_io_drive;
        assign alt_value = timer_io_out;
      end else if (gi == 4) begin : g_so
        assign alt_drive = serial_enable;
        assign alt_value = serial_data_out;
      end else if (gi == 5) begin : g_sk
        assign alt_drive = serial_enable;
        assign alt_value = serial_shift_clock_out;
      end else begin : g_none
        assign alt_drive = 1'b0;
        assign alt_value = 1'b0;
      end
      assign mix_oe[gi]     = pad[1];
      assign mix_pullup[gi] = pad[0];
      assign mix_out[gi]    = alt_drive ? alt_value : mix_data_reg[gi];
    end
  endgenerate

  // Alternate inputs see the raw pins; their units synchronise as they need.
  assign external_irq_input    = mix_in[0];
  assign timer_io_in           = mix_in[3];
  assign serial_shift_clock_in = mix_in[5];
  assign serial_data_in        = mix_in[6];

  // Crystal option drives the oscillator output; it stops with halt.
  assign osc_clock_out_or_continue_oe  = crystal_reg;
  assign osc_clock_out_or_continue_out = crystal_reg & run & cycle_en;

  // Output port reads high while reset is held: reset loads all ones.
  assign out_port             = out_data_reg;
  assign processor_status_reg = status_reg;
  assign control_reg          = ctrl_reg;
endmodule

/* File: verification/mip_pin_model.sv */
// Board-level model of the loads and levels seen by the port pins.
`timescale 1ns/10ps
module mip_pin_model (
  // Clock
  input  wire       clk,
  // Drive from the block
  input  wire [7:0] wide_out,
  input  wire [7:0] wide_oe,
  input  wire [7:0] wide_pullup,
  input  wire [5:0] mix_out,
  input  wire [5:0] mix_oe,
  input  wire [5:0] mix_pullup,
  input  wire       osc_clock_out_or_continue_out,
  input  wire       osc_clock_out_or_continue_oe,
  // Levels set by the bench
  input  wire       cont_level,
  input  wire [1:0] mix_hi,
  // Levels returned to the block
  output wire [7:0] wide_in,
  output wire [7:0] mix_in,
  output wire       osc_clock_out_or_continue_in
);
  reg [7:0] float_pat = 8'h5A;

  // An unloaded pin wanders, so a floating input never reads a stale value.
  always @(posedge clk) begin
    float_pat <= ~float_pat;
  end

  // Driven pins follow the drive, pulled pins sit high, the rest wander.
  assign wide_in = (wide_oe & wide_out) | (~wide_oe & (wide_pullup | float_pat));
  assign mix_in = {mix_hi, (mix_oe & mix_out) | (~mix_oe & (mix_pullup | float_pat[5:0]))};
  // The crystal option owns the pin, otherwise the bench drives it.
  assign osc_clock_out_or_continue_in = osc_clock_out_or_continue_oe ?
    osc_clock_out_or_continue_out : cont_level;
endmodule

/* File: verification/mip_io_ports_properties.sv */
// Port-level assertions for the I/O port block.
`timescale 1ns/10ps
`include "mip_regs.vh"
module mip_io_ports_props #(
  parameter DIVIDE = 10
) (
  // Clock, reset and strap
  input wire       clk,
  input wire       resetn,
  input wire       crystal_option,
  // Memory access
  input wire [7:0] mem_addr,
  input wire       mem_hit,
  input wire [7:0] mem_rdata,
  // Pins
  input wire [7:0] wide_out,
  input wire [7:0] wide_oe,
  input wire [7:0] wide_pullup,
  input wire [7:0] mix_in,
  input wire       osc_clock_out_or_continue_in,
  input wire       osc_clock_out_or_continue_oe,
  input wire [3:0] out_port,
  // Alternate functions and core state
  input wire       external_irq_input,
  input wire       timer_io_in,
  input wire       serial_shift_clock_in,
  input wire       serial_data_in,
  input wire       halted,
  input wire       cycle_en,
  input wire [7:0] control_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // -------------------------------------------------------------------------
  // Sequences and assertions
  // -------------------------------------------------------------------------
  // Nine quiet cycles follow every instruction-cycle pulse.
  sequence s_quiet;
    !cycle_en [*8] ##1 !cycle_en;
  endsequence
  // Halt seen on two samples in a row.
  sequence s_held;
    halted ##1 halted;
  endsequence
  chk_cycle_spacing:
    assert property (cycle_en |=> s_quiet ##1 (cycle_en || halted))
      else $error("cycle pulse spacing wrong");
  chk_halt_no_cycle:
    assert property (halted |-> !cycle_en) else $error("cycle pulse during halt");
  chk_halt_frozen:
    assert property (s_held |-> $stable(wide_oe) && $stable(wide_out) && $stable(out_port))
      else $error("state moved during halt");
  chk_reset_state:
    assert property ($rose(resetn) |-> $past(out_port) == 4'hF && $past(wide_oe) == 8'h00
      && $past(control_reg) == 8'h00 && !$past(halted)) else $error("reset state wrong");
  chk_drive_pull_excl:
    assert property ((wide_oe & wide_pullup) == 8'h00) else $error("drive with pull-up");
  chk_unmapped_zero:
    assert property (!mem_hit |=> mem_rdata == 8'h00) else $error("unmapped read not zero");
  chk_mix_cfg_zero:
    assert property (mem_addr == `MIP_ADDR_MIX_CFG |=> mem_rdata[7:6] == 2'h0)
      else $error("input-only config bits read one");
  chk_alt_inputs:
    assert property ({serial_data_in, serial_shift_clock_in, timer_io_in, external_irq_input}
      == {mix_in[6], mix_in[5], mix_in[3], mix_in[0]}) else $error("alternate input wrong");
  chk_continue_exit:
    assert property (halted && !osc_clock_out_or_continue_oe
      && $rose(osc_clock_out_or_continue_in) |-> ##[1:8] !halted) else $error("no resume");
  chk_crystal_pin:
    assert property ($rose(resetn) |-> ##2 osc_clock_out_or_continue_oe == crystal_option)
      else $error("oscillator pin mode wrong");
endmodule
bind mip_io_ports mip_io_ports_props #(.DIVIDE(DIVIDE)) u_props (.clk, .resetn,
  .crystal_option, .mem_addr, .mem_hit, .mem_rdata, .wide_out, .wide_oe, .wide_pullup,
  .mix_in, .osc_clock_out_or_continue_in, .osc_clock_out_or_continue_oe, .out_port,
  .external_irq_input, .timer_io_in, .serial_shift_clock_in, .serial_data_in, .halted,
  .cycle_en, .control_reg);

/* File: verification/tb.sv */
// Self-checking bench for the I/O port block.
`timescale 1ns/10ps
`include "mip_regs.vh"
module tb;
  reg        clk = 1'b0;
  reg        resetn = 1'b0;
  reg        crystal_option = 1'b0;
  reg  [7:0] mem_addr = 8'h00;
  reg        mem_wr = 1'b0;
  reg  [7:0] mem_wdata = 8'h00;
  reg        mem_bit_op = 1'b0;
  reg  [2:0] mem_bit_sel = 3'h0;
  reg        mem_bit_val = 1'b0;
  reg  [3:0] in_port = 4'h9;
  reg        cont_level = 1'b0;
  reg  [1:0] mix_hi = 2'h1;
  reg        alt_en = 1'b0;
  reg  [2:0] alt_val = 3'h0;
  reg  [7:0] rd_val;
  wire [7:0] mem_rdata, wide_in, wide_out, wide_oe, wide_pullup, mix_in;
  wire [7:0] processor_status_reg, control_reg;
  wire [5:0] mix_out, mix_oe, mix_pullup;
  wire [3:0] out_port;
  wire       mem_hit, osc_clock_out_or_continue_in, osc_clock_out_or_continue_out;
  wire       osc_clock_out_or_continue_oe, external_irq_input, timer_io_in;
  wire       serial_shift_clock_in, serial_data_in, halted, cycle_en;
  integer    n_mismatch = 0;
  integer    n_compared = 0;

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  // One bench enable stands in for the timer and serial units claiming their pins.
  mip_io_ports u_dut (.clk, .resetn, .crystal_option, .mem_addr, .mem_wr, .mem_wdata,
    .mem_bit_op, .mem_bit_sel, .mem_bit_val, .mem_rdata, .mem_hit, .wide_in, .wide_out,
    .wide_oe, .wide_pullup, .mix_in, .mix_out, .mix_oe, .mix_pullup,
    .osc_clock_out_or_continue_in, .osc_clock_out_or_continue_out,
    .osc_clock_out_or_continue_oe, .in_port, .out_port, .external_irq_input, .timer_io_in,
    .timer_io_out(alt_val[0]), .timer_io_drive(alt_en), .serial_data_out(alt_val[1]),
    .serial_enable(alt_en), .serial_shift_clock_in, .serial_shift_clock_out(alt_val[2]),
    .serial_data_in, .halted, .cycle_en, .processor_status_reg, .control_reg);

  mip_pin_model u_pins (.clk, .wide_out, .wide_oe, .wide_pullup, .mix_out, .mix_oe,
    .mix_pullup, .osc_clock_out_or_continue_out, .osc_clock_out_or_continue_oe, .cont_level,
    .mix_hi, .wide_in, .mix_in, .osc_clock_out_or_continue_in);

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  task tally_and_finish;
    begin
      $display("Compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input [8*10-1:0] what, input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // Stops at the falling edge just before a sampled instruction-cycle pulse.
  task wait_cyc;
    integer i;
    begin
      i = 0;
      @(negedge clk);
      while (cycle_en !== 1'b1 && i < 40) begin
        @(negedge clk);
        i = i + 1;
      end
      if (i == 40) begin
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
      end
    end
  endtask

  // Strobe held across exactly one pulse edge; a bit op writes d[0] to bit sel.
  task wr(input [7:0] a, input [7:0] d, input bop, input [2:0] sel);
    begin
      wait_cyc;
      mem_addr = a;
      mem_wdata = d;
      mem_bit_op = bop;
      mem_bit_sel = sel;
      mem_bit_val = d[0];
      mem_wr = 1'b1;
      @(negedge clk);
      mem_wr = 1'b0;
      mem_bit_op = 1'b0;
    end
  endtask

  task rd(input [7:0] a);
    begin
      @(negedge clk);
      mem_addr = a;
      @(negedge clk);
      rd_val = mem_rdata;
    end
  endtask

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task t_reset;
    begin
      chk("out_port", {4'h0, out_port}, 8'h0F);
      chk("wide_oe", wide_oe, 8'h00);
      chk("mix_oe", {2'h0, mix_oe}, 8'h00);
      rd(`MIP_ADDR_WIDE_CFG);
      chk("wide_cfg", rd_val, 8'h00);
      rd(`MIP_ADDR_MIX_DATA);
      chk("mix_data", rd_val, 8'h00);
      rd(`MIP_ADDR_CTRL);
      chk("ctrl", rd_val, 8'h00);
    end
  endtask

  task t_div;
    integer n;
    begin
      wait_cyc;
      n = 0;
      do begin
        @(negedge clk);
        n = n + 1;
      end while (cycle_en !== 1'b1 && n < 40);
      chk("divide", n[7:0], 8'h0A);
    end
  endtask

  // Mixed configuration exercises all four pin modes at once.
  task t_encode;
    begin
      wr(`MIP_ADDR_WIDE_CFG, 8'h0F, 1'b0, 3'h0);
      wr(`MIP_ADDR_WIDE_DATA, 8'h35, 1'b0, 3'h0);
      chk("wide_oe", wide_oe, 8'h0F);
      chk("wide_drv", wide_out & wide_oe, 8'h05);
      chk("pullup", wide_pullup, 8'h30);
      rd(`MIP_ADDR_WIDE_CFG);
      chk("cfg_read", rd_val, 8'h0F);
      wr(`MIP_ADDR_WIDE_CFG, 8'hFF, 1'b0, 3'h0);
      wr(`MIP_ADDR_WIDE_DATA, 8'hA5, 1'b0, 3'h0);
      repeat (3) wait_cyc;
      rd(`MIP_ADDR_WIDE_PINS);
      chk("pins", rd_val, 8'hA5);
    end
  endtask

  task t_mixed;
    begin
      wr(`MIP_ADDR_MIX_DATA, 8'h2A, 1'b0, 3'h0);
      chk("mix_pull", {2'h0, mix_pullup}, 8'h2A);
      chk("mix_oe0", {2'h0, mix_oe}, 8'h00);
      wr(`MIP_ADDR_MIX_CFG, 8'hFF, 1'b0, 3'h0);
      chk("mix_oe", {2'h0, mix_oe}, 8'h3F);
      chk("mix_out", {2'h0, mix_out}, 8'h2A);
      rd(`MIP_ADDR_MIX_CFG);
      chk("mix_cfg", rd_val, 8'h3F);
      repeat (3) wait_cyc;
      rd(`MIP_ADDR_MIX_PINS);
      chk("mix_pins", rd_val, 8'h6A);
      alt_en = 1'b1;
      alt_val = 3'h2;
      @(negedge clk);
      chk("alt_out", {2'h0, mix_out}, 8'h12);
      alt_en = 1'b0;
    end
  endtask

  task t_misc;
    begin
      wr(`MIP_ADDR_OUT_DATA, 8'h00, 1'b0, 3'h0);
      wr(`MIP_ADDR_OUT_DATA, 8'h01, 1'b1, 3'h2);
      chk("bit_set", {4'h0, out_port}, 8'h04);
      wr(`MIP_ADDR_CTRL, 8'h3C, 1'b0, 3'h0);
      wr(`MIP_ADDR_CTRL, 8'h00, 1'b1, 3'h2);
      chk("ctrl_bit", control_reg, 8'h38);
      wr(`MIP_ADDR_STATUS, 8'h01, 1'b1, 3'h7);
      chk("psr_bit", processor_status_reg, 8'h80);
      rd(8'h80);
      chk("unmapped", rd_val, 8'h00);
      rd(`MIP_ADDR_IN_PINS);
      chk("in_port", rd_val & 8'h0F, 8'h09);
    end
  endtask

  task t_halt;
    integer i;
    begin
      wr(`MIP_ADDR_MIX_DATA, 8'hAA, 1'b0, 3'h0);
      @(negedge clk);
      chk("halted", {7'h00, halted}, 8'h01);
      i = 0;
      repeat (30) begin
        @(negedge clk);
        if (cycle_en !== 1'b0) i = i + 1;
      end
      chk("halt_run", i[7:0], 8'h00);
      cont_level = 1'b1;
      i = 0;
      while (halted !== 1'b0 && i < 10) begin
        @(negedge clk);
        i = i + 1;
      end
      chk("resumed", {7'h00, halted}, 8'h00);
      if (halted !== 1'b0) tally_and_finish;
      rd(`MIP_ADDR_MIX_DATA);
      chk("mix_data", rd_val, 8'h2A);
      rd(`MIP_ADDR_WIDE_DATA);
      chk("wide_kept", rd_val, 8'hA5);
      cont_level = 1'b0;
    end
  endtask

  // Reset held for several cycles, released into the crystal option.
  task t_midreset;
    integer i;
    begin
      @(negedge clk);
      resetn = 1'b0;
      crystal_option = 1'b1;
      repeat (5) begin
        @(negedge clk);
        chk("rst_out", {4'h0, out_port}, 8'h0F);
        chk("rst_oe", wide_oe, 8'h00);
      end
      chk("rst_ctrl", control_reg, 8'h00);
      chk("rst_psr", processor_status_reg, 8'h00);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      chk("osc_oe", {7'h00, osc_clock_out_or_continue_oe}, 8'h01);
      i = 0;
      repeat (10) begin
        @(negedge clk);
        if (osc_clock_out_or_continue_out === 1'b1) i = i + 1;
      end
      chk("osc_out", i[7:0], 8'h01);
    end
  endtask

  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    t_reset;
    t_div;
    t_encode;
    t_mixed;
    t_misc;
    t_halt;
    t_midreset;
    tally_and_finish;
  end
endmodule
